// ### common/fer_pkg.sv
`default_nettype none
package fer_pkg;
  // Flash bus widths
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;

  // Software register offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_SECTOR = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;

  // Control register operation codes, in bits [2:0]
  typedef enum logic [2:0] {
    OP_NONE    = 3'h0,
    OP_CHIP    = 3'h1,
    OP_SECTOR  = 3'h2,
    OP_RESET   = 3'h3,
    OP_ADD     = 3'h4,
    OP_SUSPEND = 3'h5
  } fer_op_t;
  localparam int CTRL_OP_LSB = 0;

  // Status register field positions
  localparam int ST_BUSY     = 0;
  localparam int ST_DONE     = 1;
  localparam int ST_FAIL     = 2;
  localparam int ST_WIN      = 3;
  localparam int ST_LATE     = 4;
  localparam int ST_RDY      = 5;
  localparam int ST_LAST_LSB = 8;

  // Unlock pairs and command codes
  localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 19'h00555;
  localparam logic [DATA_W-1:0] UNLOCK1_DATA = 8'haa;
  localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 19'h002aa;
  localparam logic [DATA_W-1:0] UNLOCK2_DATA = 8'h55;
  localparam logic [ADDR_W-1:0] ANY_ADDR     = 19'h00000;
  localparam logic [DATA_W-1:0] CMD_SETUP    = 8'h80;
  localparam logic [DATA_W-1:0] CMD_CHIP     = 8'h10;
  localparam logic [DATA_W-1:0] CMD_SECTOR   = 8'h30;
  localparam logic [DATA_W-1:0] CMD_RESET    = 8'hf0;
  localparam logic [DATA_W-1:0] CMD_SUSPEND  = 8'hb0;

  // Command sequence steps
  localparam logic [2:0] STEP_FIRST = 3'h0;
  localparam logic [2:0] STEP_LAST  = 3'h5;

  // Status byte bit positions read from the device
  localparam int BIT_POLL    = 7;
  localparam int BIT_TOGGLE  = 6;
  localparam int BIT_TIMEOUT = 5;
  localparam int BIT_WINDOW  = 3;

  // Timing, figures in ns, counts in 20 ns cycles
  localparam int CLK_NS      = 20;
  localparam int SETUP_NS    = 20;
  localparam int WE_PULSE_NS = 50;
  localparam int HOLD_NS     = 30;
  localparam int ACC_NS      = 90;
  localparam int LOAD_WIN_NS = 50000;
  localparam int SYNC_CYC    = 2;
  localparam logic [3:0] SETUP_CYC = 4'((SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] PULSE_CYC = 4'((WE_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] HOLD_CYC  = 4'((HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] READ_CYC  = 4'((ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC);
  localparam logic [3:0] CNT_ONE   = 4'h1;
  // Longest time, so rounded down
  localparam logic [11:0] LOAD_WIN_CYC   = 12'(LOAD_WIN_NS / CLK_NS);
  // Next falling edge lands a few cycles after launch
  localparam logic [11:0] WIN_MARGIN_CYC = 12'h008;
  localparam logic [11:0] WIN_LAUNCH_CYC = LOAD_WIN_CYC - WIN_MARGIN_CYC;
endpackage
`default_nettype wire

// ### hdl/fer_bus_cycle.sv
`timescale 1ns/1ps
`default_nettype none
module fer_bus_cycle (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       start,
  input  wire logic                       wr,
  input  wire logic [fer_pkg::ADDR_W-1:0] addr,
  input  wire logic [fer_pkg::DATA_W-1:0] wdata,
  output logic                            done,
  output logic      [fer_pkg::DATA_W-1:0] rdata,
  output logic      [fer_pkg::ADDR_W-1:0] flash_addr,
  output logic      [fer_pkg::DATA_W-1:0] flash_dq_o,
  output logic                            flash_dq_oe,
  input  wire logic [fer_pkg::DATA_W-1:0] flash_dq_i,
  output logic                            flash_ce_n,
  output logic                            flash_we_n,
  output logic                            flash_oe_n
);
  typedef enum logic [1:0] {
    CY_IDLE   = 2'b00,
    CY_SETUP  = 2'b01,
    CY_STROBE = 2'b11,
    CY_HOLD   = 2'b10
  } fer_cy_t;

  typedef struct packed {
    fer_cy_t                    st;
    logic [3:0]                 cnt;
    logic                       wr;
    logic                       done;
    logic [fer_pkg::DATA_W-1:0] rdata;
    logic [fer_pkg::ADDR_W-1:0] addr;
    logic [fer_pkg::DATA_W-1:0] dq_o;
    logic                       dq_oe;
    logic                       ce_n;
    logic                       we_n;
    logic                       oe_n;
    logic [fer_pkg::DATA_W-1:0] s1;
    logic [fer_pkg::DATA_W-1:0] s2;
  } fer_cy_state_t;

  localparam fer_cy_state_t CY_RST = '{st: CY_IDLE, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, default: '0};

  fer_cy_state_t q;
  fer_cy_state_t d;

  // Strobe sequencing; chip select leads and trails write strobe
  always_comb begin
    d      = q;
    d.done = 1'b0;
    d.s1   = flash_dq_i;
    d.s2   = q.s1;
    unique case (q.st)
      CY_IDLE: begin
        if (start) begin
          d.st    = CY_SETUP;
          d.wr    = wr;
          d.addr  = addr;
          d.dq_o  = wdata;
          d.dq_oe = wr;
          d.ce_n  = 1'b0;
          d.oe_n  = wr;
          d.cnt   = fer_pkg::SETUP_CYC;
        end
      end
      CY_SETUP: begin
        if (q.cnt == fer_pkg::CNT_ONE) begin
          d.st   = CY_STROBE;
          d.we_n = ~q.wr; // Later falling edge latches address
          d.cnt  = q.wr ? fer_pkg::PULSE_CYC : fer_pkg::READ_CYC;
        end else begin
          d.cnt = q.cnt - fer_pkg::CNT_ONE;
        end
      end
      CY_STROBE: begin
        if (q.cnt == fer_pkg::CNT_ONE) begin
          d.st   = CY_HOLD;
          d.cnt  = fer_pkg::HOLD_CYC;
          d.we_n = 1'b1; // Earlier rising edge latches data and starts erase
          if (!q.wr) begin
            d.rdata = q.s2;
            d.oe_n  = 1'b1;
            d.ce_n  = 1'b1;
          end
        end else begin
          d.cnt = q.cnt - fer_pkg::CNT_ONE;
        end
      end
      CY_HOLD: begin
        if (q.cnt == fer_pkg::CNT_ONE) begin
          d.st    = CY_IDLE;
          d.ce_n  = 1'b1;
          d.dq_oe = 1'b0;
          d.done  = 1'b1;
        end else begin
          d.cnt = q.cnt - fer_pkg::CNT_ONE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= CY_RST;
    end else begin
      q <= d;
    end
  end

  assign done        = q.done;
  assign rdata       = q.rdata;
  assign flash_addr  = q.addr;
  assign flash_dq_o  = q.dq_o;
  assign flash_dq_oe = q.dq_oe;
  assign flash_ce_n  = q.ce_n;
  assign flash_we_n  = q.we_n;
  assign flash_oe_n  = q.oe_n;
endmodule
`default_nettype wire

// ### hdl/fer_erase_ctrl.sv
// Functional notes
// - Chip erase: unlock, unlock, 80H, unlock, unlock, 10H
// - Sector erase: same prefix, then 30H at sector
// - Extra sectors within 50us of previous rise
// - Host writes reset after timeout or identification
// - Status valid only at relevant address
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fer_erase_ctrl (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic [3:0]                 reg_addr,
  input  wire logic [31:0]                reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [31:0]                reg_rdata,
  output logic      [fer_pkg::ADDR_W-1:0] flash_addr,
  output logic      [fer_pkg::DATA_W-1:0] flash_dq_o,
  output logic                            flash_dq_oe,
  input  wire logic [fer_pkg::DATA_W-1:0] flash_dq_i,
  output logic                            flash_ce_n,
  output logic                            flash_we_n,
  output logic                            flash_oe_n,
  input  wire logic                       ready_busy_out
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SEQ  = 3'b001,
    ST_WIN  = 3'b011,
    ST_POLL = 3'b010
  } fer_st_t;

  typedef struct packed {
    fer_st_t                    st;
    fer_pkg::fer_op_t           op;
    logic [2:0]                 step;
    logic                       wait_cy;
    logic [fer_pkg::ADDR_W-1:0] sector;
    logic [fer_pkg::ADDR_W-1:0] poll_addr;
    logic [fer_pkg::ADDR_W-1:0] pend_sector;
    logic                       pend;
    logic                       susp_req;
    logic [11:0]                win_cnt;
    logic [fer_pkg::DATA_W-1:0] prev;
    logic                       have_prev;
    logic [fer_pkg::DATA_W-1:0] last;
    logic                       done;
    logic                       fail;
    logic                       late;
    logic                       rb1;
    logic                       rb2;
    logic [31:0]                rdata;
    logic                       cy_start;
    logic                       cy_wr;
    logic [fer_pkg::ADDR_W-1:0] cy_addr;
    logic [fer_pkg::DATA_W-1:0] cy_data;
  } fer_state_t;

  fer_state_t q;
  fer_state_t d;

  logic                       cy_done;
  logic [fer_pkg::DATA_W-1:0] cy_rdata;
  logic [fer_pkg::ADDR_W-1:0] step_addr;
  logic [fer_pkg::DATA_W-1:0] step_data;
  fer_pkg::fer_op_t           wr_op;
  logic                       ctrl_wr;

  assign ctrl_wr = reg_wr && (reg_addr == fer_pkg::REG_CTRL);
  assign wr_op   = fer_pkg::fer_op_t'(reg_wdata[fer_pkg::CTRL_OP_LSB +: 3]);

  // Address and data of each command cycle
  always_comb begin
    step_addr = fer_pkg::UNLOCK1_ADDR;
    step_data = fer_pkg::UNLOCK1_DATA;
    unique case (q.step)
      3'h0: begin
        step_addr = fer_pkg::UNLOCK1_ADDR;
        step_data = fer_pkg::UNLOCK1_DATA;
      end
      3'h1: begin
        step_addr = fer_pkg::UNLOCK2_ADDR;
        step_data = fer_pkg::UNLOCK2_DATA;
      end
      3'h2: begin
        step_addr = fer_pkg::UNLOCK1_ADDR;
        step_data = fer_pkg::CMD_SETUP;
      end
      3'h3: begin
        step_addr = fer_pkg::UNLOCK1_ADDR;
        step_data = fer_pkg::UNLOCK1_DATA;
      end
      3'h4: begin
        step_addr = fer_pkg::UNLOCK2_ADDR;
        step_data = fer_pkg::UNLOCK2_DATA;
      end
      default: begin
        // Final cycle depends on the operation
        unique case (q.op)
          fer_pkg::OP_CHIP: begin
            step_addr = fer_pkg::UNLOCK1_ADDR;
            step_data = fer_pkg::CMD_CHIP;
          end
          fer_pkg::OP_SECTOR: begin
            step_addr = q.sector;
            step_data = fer_pkg::CMD_SECTOR;
          end
          fer_pkg::OP_SUSPEND: begin
            step_addr = q.sector;
            step_data = fer_pkg::CMD_SUSPEND;
          end
          default: begin
            step_addr = fer_pkg::ANY_ADDR; // Address is don't care
            step_data = fer_pkg::CMD_RESET;
          end
        endcase
      end
    endcase
  end

  // Controller sequencing and register file
  always_comb begin
    d          = q;
    d.cy_start = 1'b0;
    d.rb1      = ready_busy_out;
    d.rb2      = q.rb1;
    d.rdata    = '0;
    if (cy_done) begin
      d.wait_cy = 1'b0;
    end

    // Register writes
    if (reg_wr && reg_addr == fer_pkg::REG_SECTOR) begin
      d.sector = reg_wdata[fer_pkg::ADDR_W-1:0];
    end
    if (ctrl_wr) begin
      unique case (wr_op)
        fer_pkg::OP_CHIP, fer_pkg::OP_SECTOR: begin
          if (q.st == ST_IDLE) begin
            d.st   = ST_SEQ;
            d.op   = wr_op;
            d.step = fer_pkg::STEP_FIRST;
            d.done = 1'b0;
            d.fail = 1'b0;
            d.late = 1'b0;
          end
        end
        fer_pkg::OP_RESET: begin
          // Never sent while erasing; device would ignore it
          if (q.st == ST_IDLE || q.st == ST_WIN) begin
            d.st   = ST_SEQ;
            d.op   = fer_pkg::OP_RESET;
            d.step = fer_pkg::STEP_LAST;
            d.pend = 1'b0;
            d.done = 1'b0;
          end
        end
        fer_pkg::OP_ADD: begin
          if (q.st == ST_WIN) begin
            d.pend        = 1'b1;
            d.pend_sector = reg_wdata[fer_pkg::ADDR_W-1:0] == '0 ? q.sector
                                                                  : reg_wdata[fer_pkg::ADDR_W-1:0];
          end else begin
            d.late = 1'b1;
          end
        end
        fer_pkg::OP_SUSPEND: begin
          if ((q.st == ST_WIN || q.st == ST_POLL) && q.op == fer_pkg::OP_SECTOR) begin
            d.susp_req = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    unique case (q.st)
      ST_IDLE: begin
      end
      ST_SEQ: begin
        // One command write at a time, fixed order
        if (!q.wait_cy && !cy_done) begin
          d.cy_start = 1'b1;
          d.cy_wr    = 1'b1;
          d.cy_addr  = step_addr;
          d.cy_data  = step_data;
          d.wait_cy  = 1'b1;
        end else if (cy_done) begin
          if (q.step != fer_pkg::STEP_LAST) begin
            d.step = q.step + 3'h1;
          end else begin
            unique case (q.op)
              fer_pkg::OP_CHIP: begin
                d.st        = ST_POLL;
                d.poll_addr = fer_pkg::ANY_ADDR;
                d.have_prev = 1'b0;
              end
              fer_pkg::OP_SECTOR: begin
                d.st      = ST_WIN;
                d.win_cnt = '0;
              end
              default: begin
                // Reset or suspend write ends the operation
                d.st       = ST_IDLE;
                d.done     = 1'b1;
                d.susp_req = 1'b0;
              end
            endcase
          end
        end
      end
      ST_WIN: begin
        // Timer restarts when the last load write cycle completes, after chip select rises
        if (!q.wait_cy && q.win_cnt != fer_pkg::LOAD_WIN_CYC) begin
          d.win_cnt = q.win_cnt + 12'h001;
        end
        if (q.wait_cy) begin
          if (cy_done) begin
            d.win_cnt = '0;
          end
        end else if (q.susp_req) begin
          d.st   = ST_SEQ; // Suspend ends the window at once
          d.op   = fer_pkg::OP_SUSPEND;
          d.step = fer_pkg::STEP_LAST;
          d.pend = 1'b0;
        end else if (q.pend && q.win_cnt < fer_pkg::WIN_LAUNCH_CYC) begin
          d.cy_start = 1'b1;
          d.cy_wr    = 1'b1;
          d.cy_addr  = q.pend_sector;
          d.cy_data  = fer_pkg::CMD_SECTOR;
          d.wait_cy  = 1'b1;
          d.pend     = 1'b0;
        end else if (q.pend) begin
          d.pend = 1'b0; // Too late to load; refused
          d.late = 1'b1;
        end else if (q.win_cnt == fer_pkg::LOAD_WIN_CYC) begin
          d.st        = ST_POLL;
          d.poll_addr = q.sector; // Poll inside an erased sector
          d.have_prev = 1'b0;
        end
      end
      ST_POLL: begin
        if (!q.wait_cy && !cy_done) begin
          if (q.susp_req) begin
            d.st   = ST_SEQ;
            d.op   = fer_pkg::OP_SUSPEND;
            d.step = fer_pkg::STEP_LAST;
          end else begin
            d.cy_start = 1'b1;
            d.cy_wr    = 1'b0;
            d.cy_addr  = q.poll_addr;
            d.wait_cy  = 1'b1;
          end
        end else if (cy_done) begin
          d.last      = cy_rdata;
          d.prev      = cy_rdata;
          d.have_prev = 1'b1;
          if (q.have_prev && cy_rdata[fer_pkg::BIT_POLL] &&
              cy_rdata[fer_pkg::BIT_TOGGLE] == q.prev[fer_pkg::BIT_TOGGLE]) begin
            d.st   = ST_IDLE; // Device is back in array read
            d.done = 1'b1;
          end else if (cy_rdata[fer_pkg::BIT_TIMEOUT]) begin
            // Failed erase needs a reset to read the array again
            d.fail = 1'b1;
            d.st   = ST_SEQ;
            d.op   = fer_pkg::OP_RESET;
            d.step = fer_pkg::STEP_LAST;
          end
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase

    // Read data stands one cycle after the strobe
    if (reg_rd) begin
      unique case (reg_addr)
        fer_pkg::REG_SECTOR: d.rdata = 32'(q.sector);
        fer_pkg::REG_STATUS: begin
          d.rdata[fer_pkg::ST_BUSY] = (q.st != ST_IDLE);
          d.rdata[fer_pkg::ST_DONE] = q.done;
          d.rdata[fer_pkg::ST_FAIL] = q.fail;
          d.rdata[fer_pkg::ST_WIN]  = (q.st == ST_WIN);
          d.rdata[fer_pkg::ST_LATE] = q.late;
          d.rdata[fer_pkg::ST_RDY]  = q.rb2;
          d.rdata[fer_pkg::ST_LAST_LSB +: fer_pkg::DATA_W] = q.last;
        end
        default: d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  fer_bus_cycle u_cycle (
    .clk         (clk),
    .rst         (rst),
    .start       (q.cy_start),
    .wr          (q.cy_wr),
    .addr        (q.cy_addr),
    .wdata       (q.cy_data),
    .done        (cy_done),
    .rdata       (cy_rdata),
    .flash_addr  (flash_addr),
    .flash_dq_o  (flash_dq_o),
    .flash_dq_oe (flash_dq_oe),
    .flash_dq_i  (flash_dq_i),
    .flash_ce_n  (flash_ce_n),
    .flash_we_n  (flash_we_n),
    .flash_oe_n  (flash_oe_n)
  );

  assign reg_rdata = q.rdata;
endmodule
`default_nettype wire

// ### verification/fer_erase_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module fer_erase_ctrl_sva (
  input wire logic                       clk,
  input wire logic                       rst,
  input wire logic [3:0]                 reg_addr,
  input wire logic [31:0]                reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic [31:0]                reg_rdata,
  input wire logic [fer_pkg::ADDR_W-1:0] flash_addr,
  input wire logic [fer_pkg::DATA_W-1:0] flash_dq_o,
  input wire logic                       flash_dq_oe,
  input wire logic [fer_pkg::DATA_W-1:0] flash_dq_i,
  input wire logic                       flash_ce_n,
  input wire logic                       flash_we_n,
  input wire logic                       flash_oe_n,
  input wire logic                       ready_busy_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Write strobe nests inside chip select, bus driven, no read overlap
  chk_we_in_ce: assert property (!flash_we_n |-> !flash_ce_n) else $error("we_n low outside ce_n");
  chk_dq_drive: assert property (!flash_we_n |-> flash_dq_oe && flash_oe_n) else $error("write not driven");
  // Strobe shape: one setup cycle, three low cycles, two hold cycles
  chk_ce_setup: assert property ($fell(flash_ce_n) && flash_dq_oe |-> flash_we_n ##1 $fell(flash_we_n))
    else $error("no setup before we_n");
  chk_we_width: assert property ($fell(flash_we_n) |-> !flash_we_n [*3] ##1 flash_we_n)
    else $error("we_n pulse width wrong");
  chk_ce_hold: assert property ($rose(flash_we_n) |-> !flash_ce_n [*2] ##1 flash_ce_n)
    else $error("ce_n hold wrong");
  // Address and data must not move while selected, the device latches them on edges
  chk_bus_stable: assert property (!flash_ce_n && !$past(flash_ce_n) |-> $stable(flash_addr) && $stable(flash_dq_o))
    else $error("bus moved in cycle");
  chk_setup_addr: assert property (!flash_we_n && flash_dq_o == fer_pkg::CMD_SETUP
    |-> flash_addr == fer_pkg::UNLOCK1_ADDR) else $error("setup code at wrong address");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("stray read data");
endmodule
bind fer_erase_ctrl fer_erase_ctrl_sva u_sva (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .flash_addr(flash_addr), .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe),
  .flash_dq_i(flash_dq_i), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
  .ready_busy_out(ready_busy_out)
);
`default_nettype wire

// ### verification/fer_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fer_flash_model #(
  parameter int ERASE_NS = 20000,
  parameter int WIN_NS   = 50000
) (
  input  wire logic [fer_pkg::ADDR_W-1:0] flash_addr,
  input  wire logic [fer_pkg::DATA_W-1:0] flash_dq_o,
  input  wire logic                       flash_ce_n,
  input  wire logic                       flash_we_n,
  input  wire logic                       flash_oe_n,
  input  wire logic                       fail_en,
  output logic      [fer_pkg::DATA_W-1:0] flash_dq_i,
  output logic                            ready_busy_out
);
  // Modes: 0 array read, 1 load window, 2 erasing, 3 suspended, 4 timed out
  int                         st = 0;
  int                         cyc = 0;
  realtime                    t0;
  logic [fer_pkg::ADDR_W-1:0] a_lat;
  logic [fer_pkg::ADDR_W-1:0] secs[$];
  logic [fer_pkg::DATA_W-1:0] d;
  logic [fer_pkg::DATA_W-1:0] out = 8'h00;
  logic [fer_pkg::DATA_W-1:0] last = 8'h00;
  logic                       tog = 1'b0;
  logic                       hit;
  logic                       in_sec;
  wire                        wr_n = flash_ce_n | flash_we_n;
  wire                        rd_n = flash_ce_n | flash_oe_n;

  // Address on the later fall, command on the earlier rise
  always @(negedge wr_n) a_lat = flash_addr;
  always @(posedge wr_n) begin
    d = flash_dq_o;
    if (d == fer_pkg::CMD_RESET && st != 2) begin
      st = 0;
      cyc = 0;
    end else if (st == 1 && d == fer_pkg::CMD_SECTOR) begin
      secs.push_back(a_lat);
      t0 = $realtime;
    end else if (st == 1) st = (d == fer_pkg::CMD_SUSPEND) ? 3 : 0;
    else if (st == 0) begin
      case (cyc)
        0, 3: hit = a_lat == fer_pkg::UNLOCK1_ADDR && d == fer_pkg::UNLOCK1_DATA;
        1, 4: hit = a_lat == fer_pkg::UNLOCK2_ADDR && d == fer_pkg::UNLOCK2_DATA;
        2: hit = d == fer_pkg::CMD_SETUP;
        default: hit = d == fer_pkg::CMD_CHIP || d == fer_pkg::CMD_SECTOR;
      endcase
      if (!hit || cyc < 5) cyc = hit ? cyc + 1 : 0;
      else begin
        cyc = 0;
        t0 = $realtime;
        secs = {a_lat};
        st = (d == fer_pkg::CMD_CHIP) ? 2 : 1;
      end
    end
  end

  // Coarse internal tick; preprogram and erase folded into one span
  always #100 begin
    if (st == 1 && $realtime - t0 > WIN_NS) begin
      st = 2;
      t0 = $realtime;
    end else if (st == 2 && $realtime - t0 > ERASE_NS) st = fail_en ? 4 : 0;
  end

  // Status replaces array data while busy or at a suspended sector
  always @(negedge rd_n) begin
    in_sec = 1'b0;
    foreach (secs[i]) if (secs[i] == flash_addr) in_sec = 1'b1;
    if (st == 1 || st == 2 || st == 4) tog = ~tog;
    case (st)
      1, 2, 4: out = {1'b0, tog, st == 4, 1'b0, st != 1, 3'b000};
      3: out = in_sec ? {1'b1, tog, 6'h00} : 8'hff;
      default: out = 8'hff;
    endcase
  end
  always @(posedge rd_n) last = out;
  // Released bus shows the inverse of the last byte so stale data never passes
  assign flash_dq_i = rd_n ? ~last : out;
  assign ready_busy_out = !(st == 2 || st == 4);
endmodule
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module testbench;
  logic                       clk, rst, reg_wr, reg_rd, dq_oe, ce_n, we_n, oe_n, rdy, tmo;
  logic [3:0]                 reg_addr;
  logic [31:0]                reg_wdata, reg_rdata, st;
  logic [fer_pkg::ADDR_W-1:0] fa, sec;
  logic [fer_pkg::DATA_W-1:0] dq_o, dq_i, dq_m;
  logic [26:0]                exp_q[$], got_q[$];
  int                         n_fail = 0, n_tests = 0, seed = 32'h1ae1175c;

  fer_erase_ctrl u_dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .flash_addr(fa), .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_dq_i(dq_i),
    .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n), .ready_busy_out(rdy)
  );
  fer_flash_model u_flash (
    .flash_addr(fa), .flash_dq_o(dq_o), .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n),
    .fail_en(tmo), .flash_dq_i(dq_m), .ready_busy_out(rdy)
  );
  // Data wire level from both drivers
  assign dq_i = dq_oe ? dq_o : dq_m;

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Every completed flash write lands in the log
  always @(posedge we_n) if (!rst) got_q.push_back({fa, dq_o});

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 st = reg_rdata;
    @(posedge clk);
  endtask
  // Poll status until a bit takes a value, bounded
  task automatic wait_bit(input int b, input logic v);
    int i;
    for (i = 0; i < 3000; i++) begin
      rd(fer_pkg::REG_STATUS);
      if (st[b] === v) break;
    end
    if (i == 3000) begin
      n_fail++;
      $display("[FAIL] %0t status wait ran out", $time);
      report_and_stop;
    end
  endtask
  task automatic ex(input logic [fer_pkg::ADDR_W-1:0] a, input logic [fer_pkg::DATA_W-1:0] d);
    exp_q.push_back({a, d});
  endtask
  // Five-write prefix plus the final code
  task automatic ex_erase(input logic [fer_pkg::ADDR_W-1:0] a, input logic [fer_pkg::DATA_W-1:0] d);
    ex(fer_pkg::UNLOCK1_ADDR, fer_pkg::UNLOCK1_DATA);
    ex(fer_pkg::UNLOCK2_ADDR, fer_pkg::UNLOCK2_DATA);
    ex(fer_pkg::UNLOCK1_ADDR, fer_pkg::CMD_SETUP);
    ex(fer_pkg::UNLOCK1_ADDR, fer_pkg::UNLOCK1_DATA);
    ex(fer_pkg::UNLOCK2_ADDR, fer_pkg::UNLOCK2_DATA);
    ex(a, d);
  endtask
  task automatic check_log;
    logic [26:0] g, e;
    `CHK(got_q.size(), exp_q.size())
    while (got_q.size() > 0 && exp_q.size() > 0) begin
      g = got_q.pop_front();
      e = exp_q.pop_front();
      `CHK(g, e)
    end
    got_q.delete();
    exp_q.delete();
  endtask
  task automatic check_status(input logic done, input logic fail);
    wait_bit(fer_pkg::ST_BUSY, 1'b0);
    `CHK(st[fer_pkg::ST_DONE], done)
    `CHK(st[fer_pkg::ST_FAIL], fail)
    `CHK(st[fer_pkg::ST_RDY], 1'b1)
  endtask

  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    tmo = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Idle after reset, unmapped read gives zero
    rd(fer_pkg::REG_STATUS);
    `CHK(st[fer_pkg::ST_BUSY], 1'b0)
    rd(4'hc);
    `CHK(st, 32'h0)
    $display("test idle finished");
    // Chip erase runs to completion, last byte is erased data
    ex_erase(fer_pkg::UNLOCK1_ADDR, fer_pkg::CMD_CHIP);
    wr(fer_pkg::REG_CTRL, 32'(fer_pkg::OP_CHIP));
    check_status(1'b1, 1'b0);
    `CHK(st[15:8], 8'hff)
    check_log;
    $display("test chip erase finished");
    // Sector erase at a random sector, second sector queued inside the window
    sec = 19'($random(seed)) | 19'h10000;
    ex_erase(sec, fer_pkg::CMD_SECTOR);
    ex(19'h4, fer_pkg::CMD_SECTOR);
    wr(fer_pkg::REG_SECTOR, {13'h0, sec});
    wr(fer_pkg::REG_CTRL, 32'(fer_pkg::OP_SECTOR));
    wait_bit(fer_pkg::ST_WIN, 1'b1);
    wr(fer_pkg::REG_SECTOR, 32'h4);
    wr(fer_pkg::REG_CTRL, 32'(fer_pkg::OP_ADD));
    check_status(1'b1, 1'b0);
    check_log;
    // Add after the window closed is refused
    wr(fer_pkg::REG_CTRL, 32'(fer_pkg::OP_ADD));
    rd(fer_pkg::REG_STATUS);
    `CHK(st[fer_pkg::ST_LATE], 1'b1)
    check_log;
    $display("test sector erase finished");
    // Plain reset write, address bits zero
    ex(fer_pkg::ANY_ADDR, fer_pkg::CMD_RESET);
    wr(fer_pkg::REG_CTRL, 32'(fer_pkg::OP_RESET));
    wait_bit(fer_pkg::ST_BUSY, 1'b0);
    check_log;
    // Erase that overruns its time limit, then the recovery reset
    tmo <= 1'b1;
    ex_erase(fer_pkg::UNLOCK1_ADDR, fer_pkg::CMD_CHIP);
    ex(fer_pkg::ANY_ADDR, fer_pkg::CMD_RESET);
    wr(fer_pkg::REG_CTRL, 32'(fer_pkg::OP_CHIP));
    check_status(1'b1, 1'b1);
    check_log;
    tmo <= 1'b0;
    $display("test timeout finished");
    // Suspend written while the load window is open
    sec = 19'($random(seed)) | 19'h20000;
    ex_erase(sec, fer_pkg::CMD_SECTOR);
    ex(sec, fer_pkg::CMD_SUSPEND);
    wr(fer_pkg::REG_SECTOR, {13'h0, sec});
    wr(fer_pkg::REG_CTRL, 32'(fer_pkg::OP_SECTOR));
    wait_bit(fer_pkg::ST_WIN, 1'b1);
    wr(fer_pkg::REG_CTRL, 32'(fer_pkg::OP_SUSPEND));
    wait_bit(fer_pkg::ST_BUSY, 1'b0);
    check_log;
    $display("test suspend finished");
    report_and_stop;
  end
endmodule
`default_nettype wire
